// *** rtl/gsc_global_id_start.sv ***
// global identity, start control and table purge triggers behind the serial management port
// ****************************************************************
// Functional notes
// - revision field bits 3:1, read only
// - managed straps: run only after run bit
// - run bit zero keeps fabric stopped in managed modes only
// - straps low: auto start after eeprom attempt
// - no eeprom: keep built-in defaults
// - eeprom id checked before overriding defaults
// - bit 7 enables alternative back-off
// - bit 5 launches learned purge, self-clears
// - learned purge limited to learning-off ports
// - bit 4 launches fixed purge, self-clears
// - fixed entry qualifies: unicast, single learning-off port
// - eight-bit registers, upper byte zero/ignored
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none
module gsc_global_id_start
  import gsc_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
  parameter logic [3:0] PART_CODE = 4'h3, // arbitrary value
  parameter logic [2:0] REVISION_CODE = 3'h2, // arbitrary value
  parameter logic [3:0] EE_ID_NIBBLE = 4'h1 // arbitrary value
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic mdc, // management clock pin
  input wire logic mdio_in, // management data pin level
  output logic mdio_out, // management data drive value
  output logic mdio_oe, // management data drive enable
  input wire logic boot_strap_hi, // boot mode strap, high bit
  input wire logic boot_strap_lo, // boot mode strap, low bit
  input wire logic eeprom_done, // eeprom attempt finished, pulse
  input wire logic eeprom_present, // eeprom answered, valid with done
  input wire logic [7:0] eeprom_id0, // eeprom first byte
  input wire logic [3:0] eeprom_id1_hi, // eeprom second byte upper nibble
  output logic eeprom_override, // eeprom contents replace defaults
  output logic switch_run, // switch fabric running
  output logic backoff_alt_en, // alternative back-off enabled
  input wire logic [GSC_PORTS-1:0] learn_off, // per-port learning disabled
  output logic learned_purge_req, // learned table purge request
  input wire logic learned_purge_done, // learned purge finished, pulse
  output logic [GSC_PORTS-1:0] purge_port_mask, // ports whose entries may go
  output logic fixed_purge_req, // fixed table purge request
  input wire logic fixed_purge_done, // fixed purge finished, pulse
  input wire logic fixed_entry_mcast, // entry under test is multicast
  input wire logic [GSC_PORTS-1:0] fixed_entry_fwd, // entry forward port mask
  output logic fixed_entry_qualifies // entry may be purged
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic one_hot(input logic [GSC_PORTS-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < GSC_PORTS; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n == 4'h1;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic mdc_s1, mdc_s2, mdc_s3;
  logic mdio_s1, mdio_s2;
  logic [1:0] strap_s1, strap_s2;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
    end else begin
      mdc_s1 <= mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
      strap_s1 <= {boot_strap_hi, boot_strap_lo};
      strap_s2 <= strap_s1;
    end
  end

  logic mdc_rise;
  assign mdc_rise = mdc_s2 && !mdc_s3;

  // ****************************************************************
  // register bank state
  // ****************************************************************
  logic run_bit, backoff, learned_busy, fixed_busy;
  logic [1:0] boot_mode, strap_wait;
  logic strap_taken, auto_done, ee_ok;
  logic next_run_bit, next_backoff, next_learned_busy, next_fixed_busy;
  logic [1:0] next_boot_mode, next_strap_wait;
  logic next_strap_taken, next_auto_done, next_ee_ok;
  logic wr_en;
  logic [7:0] wr_addr, wr_data;

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      GSC_OFF_FAMILY: d = FAMILY_CODE;
      GSC_OFF_PART_RUN: begin
        d[7:GSC_PART_LSB] = PART_CODE;
        d[GSC_REV_MSB:GSC_REV_LSB] = REVISION_CODE;
        d[GSC_RUN_BIT] = run_bit;
      end
      GSC_OFF_GCTL0: begin
        d[GSC_BACKOFF_BIT] = backoff;
        d[GSC_LEARNED_PURGE_BIT] = learned_busy;
        d[GSC_FIXED_PURGE_BIT] = fixed_busy;
      end
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  always_comb begin
    next_run_bit = run_bit;
    next_backoff = backoff;
    next_learned_busy = learned_busy;
    next_fixed_busy = fixed_busy;
    next_boot_mode = boot_mode;
    next_strap_taken = strap_taken;
    next_strap_wait = {strap_wait[0], 1'b1};
    next_auto_done = auto_done;
    next_ee_ok = ee_ok;
    // straps are caught once, after the synchroniser has filled
    if (strap_wait[1] && !strap_taken) begin
      next_boot_mode = strap_s2;
      next_strap_taken = 1'b1;
    end
    if (boot_mode == GSC_BOOT_AUTO && strap_taken && eeprom_done && !auto_done) begin
      next_auto_done = 1'b1;
      // absent eeprom leaves defaults untouched
      next_ee_ok = eeprom_present && eeprom_id0 == FAMILY_CODE
                   && eeprom_id1_hi == EE_ID_NIBBLE;
    end
    // purge completion clears, a new trigger in the same cycle wins
    if (learned_purge_done) begin
      next_learned_busy = 1'b0;
    end
    if (fixed_purge_done) begin
      next_fixed_busy = 1'b0;
    end
    if (wr_en) begin
      case (wr_addr)
        GSC_OFF_PART_RUN: next_run_bit = wr_data[GSC_RUN_BIT];
        GSC_OFF_GCTL0: begin
          next_backoff = wr_data[GSC_BACKOFF_BIT];
          if (wr_data[GSC_LEARNED_PURGE_BIT]) begin
            next_learned_busy = 1'b1;
          end
          if (wr_data[GSC_FIXED_PURGE_BIT]) begin
            next_fixed_busy = 1'b1;
          end
        end
        default: next_run_bit = run_bit;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_bit <= GSC_RUN_RST;
      backoff <= GSC_BACKOFF_RST;
      learned_busy <= GSC_PURGE_RST;
      fixed_busy <= GSC_PURGE_RST;
      boot_mode <= GSC_BOOT_AUTO;
      strap_taken <= 1'b0;
      strap_wait <= 2'h0;
      auto_done <= 1'b0;
      ee_ok <= 1'b0;
    end else begin
      run_bit <= next_run_bit;
      backoff <= next_backoff;
      learned_busy <= next_learned_busy;
      fixed_busy <= next_fixed_busy;
      boot_mode <= next_boot_mode;
      strap_taken <= next_strap_taken;
      strap_wait <= next_strap_wait;
      auto_done <= next_auto_done;
      ee_ok <= next_ee_ok;
    end
  end

  // ****************************************************************
  // outputs to the switch core
  // ****************************************************************
  always_comb begin
    case (boot_mode)
      GSC_BOOT_AUTO: switch_run = auto_done;
      GSC_BOOT_MGD_A, GSC_BOOT_MGD_B: switch_run = run_bit && strap_taken;
      // factory test combination never runs the fabric from here
      default: switch_run = 1'b0;
    endcase
  end

  assign eeprom_override = ee_ok;
  assign backoff_alt_en = backoff;
  assign learned_purge_req = learned_busy;
  assign fixed_purge_req = fixed_busy;
  assign purge_port_mask = learn_off;
  assign fixed_entry_qualifies = !fixed_entry_mcast && one_hot(fixed_entry_fwd)
                                 && ((fixed_entry_fwd & learn_off) != '0);

  // ****************************************************************
  // serial management frame engine
  // ****************************************************************
  gsc_state_e st, next_st;
  logic [5:0] ones, next_ones;
  logic [4:0] cnt, next_cnt;
  logic [11:0] hdr, next_hdr;
  logic [15:0] sh, next_sh;
  logic is_rd, next_is_rd;
  logic next_mdio_out, next_mdio_oe;

  always_comb begin
    next_st = st;
    next_ones = ones;
    next_cnt = cnt;
    next_hdr = hdr;
    next_sh = sh;
    next_is_rd = is_rd;
    next_mdio_out = mdio_out;
    next_mdio_oe = mdio_oe;
    wr_en = 1'b0;
    wr_addr = {hdr[9:8], hdr[5], hdr[4:0]};
    wr_data = 8'h00;
    if (mdc_rise) begin
      case (st)
        GSC_ST_PRE: begin
          if (mdio_s2) begin
            next_ones = (ones == GSC_PRE_ONES) ? ones : ones + 6'h01;
          end else if (ones == GSC_PRE_ONES) begin
            next_st = GSC_ST_SOF;
          end else begin
            next_ones = 6'h00;
          end
        end
        GSC_ST_SOF: begin
          next_ones = 6'h00;
          next_cnt = 5'h00;
          next_st = mdio_s2 ? GSC_ST_HDR : GSC_ST_PRE;
        end
        GSC_ST_HDR: begin
          next_hdr = {hdr[10:0], mdio_s2};
          next_cnt = cnt + 5'h01;
          if (cnt == GSC_HDR_LAST) begin
            next_cnt = 5'h00;
            next_st = GSC_ST_PRE;
            // frames for other addresses are left to the port logic
            if (next_hdr[7:6] == GSC_PHY_SEL) begin
              if (next_hdr[11:10] == GSC_OP_READ) begin
                next_is_rd = 1'b1;
                next_st = GSC_ST_TA;
                // upper byte always reads as zero
                next_sh = {8'h00, reg_read({next_hdr[9:8], next_hdr[5], next_hdr[4:0]})};
              end else if (next_hdr[11:10] == GSC_OP_WRITE) begin
                next_is_rd = 1'b0;
                next_st = GSC_ST_TA;
              end
            end
          end
        end
        GSC_ST_TA: begin
          next_cnt = cnt + 5'h01;
          if (is_rd && cnt == 5'h00) begin
            next_mdio_oe = 1'b1;
            next_mdio_out = 1'b0;
          end
          if (cnt == GSC_TA_LAST) begin
            next_cnt = 5'h00;
            next_st = GSC_ST_DATA;
            if (is_rd) begin
              next_mdio_out = sh[15];
              next_sh = {sh[14:0], 1'b0};
            end
          end
        end
        GSC_ST_DATA: begin
          next_cnt = cnt + 5'h01;
          if (is_rd) begin
            next_mdio_out = sh[15];
            next_sh = {sh[14:0], 1'b0};
          end else begin
            next_sh = {sh[14:0], mdio_s2};
          end
          if (cnt == GSC_DATA_LAST) begin
            next_cnt = 5'h00;
            next_st = GSC_ST_PRE;
            next_mdio_oe = 1'b0;
            next_mdio_out = 1'b0;
            // only the low byte is stored, the upper is ignored
            wr_en = !is_rd;
            wr_data = next_sh[7:0];
          end
        end
        default: next_st = GSC_ST_PRE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= GSC_ST_PRE;
      ones <= 6'h00;
      cnt <= 5'h00;
      hdr <= 12'h000;
      sh <= 16'h0000;
      is_rd <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      st <= next_st;
      ones <= next_ones;
      cnt <= next_cnt;
      hdr <= next_hdr;
      sh <= next_sh;
      is_rd <= next_is_rd;
      mdio_out <= next_mdio_out;
      mdio_oe <= next_mdio_oe;
    end
  end

endmodule
`default_nettype wire

// *** rtl/gsc_pkg.sv ***
// constants for the global identity and start control register bank
package gsc_pkg;
  // register offsets on the serial management port
  localparam logic [7:0] GSC_OFF_FAMILY = 8'h00;
  localparam logic [7:0] GSC_OFF_PART_RUN = 8'h01;
  localparam logic [7:0] GSC_OFF_GCTL0 = 8'h02;
  // field positions
  localparam int GSC_RUN_BIT = 0;
  localparam int GSC_REV_LSB = 1;
  localparam int GSC_REV_MSB = 3;
  localparam int GSC_PART_LSB = 4;
  localparam int GSC_FIXED_PURGE_BIT = 4;
  localparam int GSC_LEARNED_PURGE_BIT = 5;
  localparam int GSC_BACKOFF_BIT = 7;
  // reset values
  localparam logic GSC_RUN_RST = 1'b0;
  localparam logic GSC_BACKOFF_RST = 1'b0;
  localparam logic GSC_PURGE_RST = 1'b0;
  // boot strap modes {hi, lo}
  localparam logic [1:0] GSC_BOOT_AUTO = 2'h0;
  localparam logic [1:0] GSC_BOOT_MGD_A = 2'h1;
  localparam logic [1:0] GSC_BOOT_MGD_B = 2'h2;
  // serial frame layout
  localparam logic [5:0] GSC_PRE_ONES = 6'h20;
  localparam logic [4:0] GSC_HDR_LAST = 5'h0b;
  localparam logic [4:0] GSC_TA_LAST = 5'h01;
  localparam logic [4:0] GSC_DATA_LAST = 5'h0f;
  localparam logic [1:0] GSC_OP_READ = 2'h2;
  localparam logic [1:0] GSC_OP_WRITE = 2'h1;
  localparam logic [1:0] GSC_PHY_SEL = 2'h3;
  localparam int GSC_PORTS = 5;
  typedef enum logic [2:0] {
    GSC_ST_PRE = 3'b000,
    GSC_ST_SOF = 3'b001,
    GSC_ST_HDR = 3'b010,
    GSC_ST_TA = 3'b011,
    GSC_ST_DATA = 3'b100
  } gsc_state_e;
endpackage

// *** dv/gsc_global_id_start_asserts.sv ***
// assertion checker for the identity and start control bank
`timescale 1ns/100ps
`default_nettype none
module gsc_global_id_start_asserts
  import gsc_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h5a, // arbitrary value
  parameter logic [3:0] EE_ID_NIBBLE = 4'h1 // arbitrary value
) (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset
  input wire logic boot_strap_hi, // strap
  input wire logic boot_strap_lo, // strap
  input wire logic eeprom_done, // eeprom end
  input wire logic eeprom_present, // eeprom seen
  input wire logic [7:0] eeprom_id0, // byte 0
  input wire logic [3:0] eeprom_id1_hi, // byte 1 hi
  input wire logic eeprom_override, // loaded
  input wire logic switch_run, // running
  input wire logic [GSC_PORTS-1:0] learn_off, // no learning
  input wire logic learned_purge_req, // purge req
  input wire logic learned_purge_done, // purge end
  input wire logic [GSC_PORTS-1:0] purge_port_mask, // ports
  input wire logic fixed_purge_req, // purge req
  input wire logic fixed_purge_done, // purge end
  input wire logic fixed_entry_mcast, // multicast
  input wire logic [GSC_PORTS-1:0] fixed_entry_fwd, // fwd mask
  input wire logic fixed_entry_qualifies // may go
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_auto;
    !boot_strap_hi && !boot_strap_lo;
  endsequence
  sequence s_auto_done;
    s_auto ##0 eeprom_done;
  endsequence
  sequence s_id_ok;
    eeprom_present && eeprom_id0 == FAMILY_CODE && eeprom_id1_hi == EE_ID_NIBBLE;
  endsequence
  sequence s_id_bad;
    !(eeprom_present && eeprom_id0 == FAMILY_CODE && eeprom_id1_hi == EE_ID_NIBBLE);
  endsequence
  AST_PORT_MASK: assert property (purge_port_mask == learn_off)
    else $error("purge mask wrong");
  AST_ENTRY_QUAL:
    assert property (fixed_entry_qualifies == (!fixed_entry_mcast &&
      $onehot(fixed_entry_fwd) && (|(fixed_entry_fwd & learn_off))))
    else $error("entry qualify wrong");
  AST_LRN_HOLD:
    assert property (learned_purge_req && !learned_purge_done |=> learned_purge_req)
    else $error("learned purge dropped early");
  AST_LRN_END: assert property (learned_purge_done |=> !learned_purge_req)
    else $error("learned purge not cleared");
  AST_FIX_HOLD:
    assert property (fixed_purge_req && !fixed_purge_done |=> fixed_purge_req)
    else $error("fixed purge dropped early");
  AST_FIX_END: assert property (fixed_purge_done |=> !fixed_purge_req)
    else $error("fixed purge not cleared");
  AST_AUTO_WAIT:
    assert property (s_auto ##0 (!eeprom_done && !switch_run) |=> !switch_run)
    else $error("auto start too early");
  AST_AUTO_GO: assert property (s_auto_done |=> switch_run [*3])
    else $error("auto start missing");
  AST_OVR_SET: assert property (s_auto_done ##0 s_id_ok |=> eeprom_override)
    else $error("eeprom not loaded");
  AST_OVR_KEEP: assert property (s_auto_done ##0 s_id_bad |=> !eeprom_override)
    else $error("defaults overridden");
endmodule
bind gsc_global_id_start gsc_global_id_start_asserts #(.FAMILY_CODE(FAMILY_CODE),
  .EE_ID_NIBBLE(EE_ID_NIBBLE)) u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .boot_strap_hi(boot_strap_hi), .boot_strap_lo(boot_strap_lo), .eeprom_done(eeprom_done),
  .eeprom_present(eeprom_present), .eeprom_id0(eeprom_id0), .eeprom_id1_hi(eeprom_id1_hi),
  .eeprom_override(eeprom_override), .switch_run(switch_run), .learn_off(learn_off),
  .learned_purge_req(learned_purge_req), .learned_purge_done(learned_purge_done),
  .purge_port_mask(purge_port_mask), .fixed_purge_req(fixed_purge_req),
  .fixed_purge_done(fixed_purge_done), .fixed_entry_mcast(fixed_entry_mcast),
  .fixed_entry_fwd(fixed_entry_fwd), .fixed_entry_qualifies(fixed_entry_qualifies));
`default_nettype wire

// *** dv/gsc_mgmt_host.sv ***
// management processor model driving serial register frames
`timescale 1ns/100ps
`default_nettype none
module gsc_mgmt_host
  import gsc_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic mdio_out, // device data
  input wire logic mdio_oe, // device enable
  output logic mdc, // management clock
  output logic mdio_in // resolved data line
);
  logic m_oe = 1'b0;
  logic m_d = 1'b1;
  // pulled up: a released line reads one
  assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_d : 1'b1);
  initial mdc = 1'b0;
  // 15 cycle bit time keeps mdc well under 10 MHz
  task automatic bit_t(input logic oe, input logic d, output logic smp);
    @(negedge clk_sys);
    mdc = 1'b0;
    m_oe = oe;
    m_d = d;
    repeat (7) @(negedge clk_sys);
    smp = mdio_in;
    mdc = 1'b1;
    repeat (7) @(negedge clk_sys);
  endtask
  task automatic xfer(input logic [1:0] op, input logic [7:0] adr, input logic [15:0] wd,
    output logic [15:0] rd);
    logic [15:0] hd;
    logic s;
    logic rdn;
    rdn = (op == GSC_OP_READ);
    hd = {2'b01, op, adr[7:6], 2'b11, adr[5], adr[4:0], 2'b10};
    for (int i = 0; i < 32; i++) bit_t(1'b1, 1'b1, s);
    for (int i = 15; i >= 0; i--) bit_t(!(rdn && i < 2), hd[i], s);
    for (int i = 15; i >= 0; i--) begin
      bit_t(!rdn, wd[i], s);
      rd[i] = s;
    end
    m_oe = 1'b0;
    mdc = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// testbench for the identity and start control bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import gsc_pkg::*;
  localparam logic [7:0] FAM = 8'h3c; // arbitrary value
  localparam logic [3:0] PRT = 4'h7; // arbitrary value
  localparam logic [2:0] REV = 3'h5; // arbitrary value
  localparam logic [3:0] NIB = 4'h9; // arbitrary value
  logic clk_sys = 1'b0;
  logic rstn, mdc, mdio_in, mdio_out, mdio_oe, boot_strap_hi, boot_strap_lo;
  logic eeprom_done, eeprom_present, eeprom_override, switch_run, backoff_alt_en;
  logic learned_purge_req, learned_purge_done, fixed_purge_req, fixed_purge_done;
  logic fixed_entry_mcast, fixed_entry_qualifies;
  logic [7:0] eeprom_id0;
  logic [3:0] eeprom_id1_hi;
  logic [GSC_PORTS-1:0] learn_off, purge_port_mask, fixed_entry_fwd;
  int err_total = 0;
  int comparisons = 0;
  logic [6:0] qt [6] = '{7'h03, 7'h04, 7'h09, 7'h42, 7'h0a, 7'h00};
  logic [12:0] ee [4] = '{{1'b1, FAM, NIB}, {1'b0, FAM, NIB}, {1'b1, FAM ^ 8'h01, NIB},
    {1'b1, FAM, NIB ^ 4'h1}};
  always #4 clk_sys = ~clk_sys;
  gsc_mgmt_host u_gsc_mgmt_host (.clk_sys(clk_sys), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));
  gsc_global_id_start #(.FAMILY_CODE(FAM), .PART_CODE(PRT), .REVISION_CODE(REV),
    .EE_ID_NIBBLE(NIB)) u_gsc_global_id_start (.clk_sys(clk_sys), .rstn(rstn), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .boot_strap_hi(boot_strap_hi), .boot_strap_lo(boot_strap_lo), .eeprom_done(eeprom_done),
    .eeprom_present(eeprom_present), .eeprom_id0(eeprom_id0), .eeprom_id1_hi(eeprom_id1_hi),
    .eeprom_override(eeprom_override), .switch_run(switch_run),
    .backoff_alt_en(backoff_alt_en), .learn_off(learn_off),
    .learned_purge_req(learned_purge_req), .learned_purge_done(learned_purge_done),
    .purge_port_mask(purge_port_mask), .fixed_purge_req(fixed_purge_req),
    .fixed_purge_done(fixed_purge_done), .fixed_entry_mcast(fixed_entry_mcast),
    .fixed_entry_fwd(fixed_entry_fwd), .fixed_entry_qualifies(fixed_entry_qualifies));
  // ****************************************************************
  // access and check tasks
  // ****************************************************************
  task automatic final_report();
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    u_gsc_mgmt_host.xfer(GSC_OP_READ, a, 16'h0000, v);
    chk(v, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] v;
    u_gsc_mgmt_host.xfer(GSC_OP_WRITE, a, d, v);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic boot(input logic [1:0] m);
    rstn = 1'b0;
    {boot_strap_hi, boot_strap_lo} = m;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
  initial begin
    repeat (80000) @(posedge clk_sys);
    err_total++;
    final_report();
  end
  initial begin
    {eeprom_done, eeprom_present, eeprom_id0, eeprom_id1_hi} = 14'h0;
    {learned_purge_done, fixed_purge_done, fixed_entry_mcast} = 3'h0;
    learn_off = 5'h05;
    fixed_entry_fwd = 5'h00;
    for (int m = 1; m < 3; m++) begin
      boot(m[1:0]);
      chk(16'(switch_run), 16'h0);
      rd(GSC_OFF_PART_RUN, {8'h00, PRT, REV, 1'b0});
      wr(GSC_OFF_PART_RUN, 16'hfff1);
      rd(GSC_OFF_PART_RUN, {8'h00, PRT, REV, 1'b1});
      chk(16'(switch_run), 16'h1);
      wr(GSC_OFF_PART_RUN, 16'h0000);
      chk(16'(switch_run), 16'h0);
    end
    wr(GSC_OFF_FAMILY, 16'hffff);
    rd(GSC_OFF_FAMILY, {8'h00, FAM});
    wr(8'h03, 16'h00ff);
    rd(8'h03, 16'h0000);
    wr(GSC_OFF_GCTL0, 16'h00cf);
    rd(GSC_OFF_GCTL0, 16'h0080);
    chk(16'(backoff_alt_en), 16'h1);
    chk(16'(purge_port_mask), 16'h0005);
    wr(GSC_OFF_GCTL0, 16'h00b0);
    chk(16'({learned_purge_req, fixed_purge_req}), 16'h3);
    rd(GSC_OFF_GCTL0, 16'h00b0);
    learned_purge_done = 1'b1;
    @(negedge clk_sys);
    learned_purge_done = 1'b0;
    rd(GSC_OFF_GCTL0, 16'h0090);
    fixed_purge_done = 1'b1;
    @(negedge clk_sys);
    fixed_purge_done = 1'b0;
    rd(GSC_OFF_GCTL0, 16'h0080);
    wr(GSC_OFF_GCTL0, 16'h0000);
    chk(16'(backoff_alt_en), 16'h0);
    for (int i = 0; i < 6; i++) begin
      {fixed_entry_mcast, fixed_entry_fwd} = qt[i][6:1];
      @(negedge clk_sys);
      chk(16'(fixed_entry_qualifies), 16'(qt[i][0]));
    end
    for (int k = 0; k < 4; k++) begin
      boot(GSC_BOOT_AUTO);
      repeat (20) @(negedge clk_sys);
      chk(16'(switch_run), 16'h0);
      {eeprom_present, eeprom_id0, eeprom_id1_hi} = ee[k];
      eeprom_done = 1'b1;
      @(negedge clk_sys);
      eeprom_done = 1'b0;
      @(negedge clk_sys);
      chk(16'(switch_run), 16'h1);
      chk(16'(eeprom_override), 16'(k == 0));
    end
    final_report();
  end
endmodule
`default_nettype wire
